// >>> core/ssl_pkg.sv
// Shared constants for the switch shift-and-latch control block
//
// Function
// R1 - Sixteen-bit shift register takes serial data, most significant bit first.
// R2 - Serial input is sampled on every rising serial clock edge.
// R3 - Rising latch-hold edge freezes all channel states at present values.
// R4 - Latch-hold low and force-off low: channels follow shift register updates.
// R5 - Latch-hold high: shifting does not change channels until it goes low.
// R6 - Chain output is last stage, serial input delayed sixteen clocks.
// R7 - System chains outputs to next inputs, shares clock and latch-hold lines.
// R8 - Controller shifts sixteen bits per device while latch-hold stays high; t_pass shifts 16'h8001 with latch-hold low.
// R9 - Controller pulses latch-hold low after full load, then back high.
// R10 - Controller finishes loading 25 ns before latch-hold rises.
// R11 - Force-off high turns all sixteen channels off regardless of data.
// R12 - Force-off low again lets channels follow the latch path.
// R13 - Force-off overrides every other input including latch-hold and data.
// R14 - Shifting and chain output continue while latch-hold or force-off high.
// R15 - Each channel obeys only its own bit; one is on, zero off.
// R16 - All sixteen channels are off after power-up.
// R17 - Controller waits 500 us after power-up before any serial write; the controller model waits 100 ns.
// R18 - Serial clock stays at or below 72 MHz, daisy chain included; the controller model runs a 6 ns period.
// R19 - Channel 15 bit shifts first; stage k drives channel k.
package ssl_pkg;
	localparam int SSL_CHANNELS = 16;
	localparam logic [15:0] SSL_SHIFT_RESET = 16'h0000;
	localparam logic [15:0] SSL_ALL_OFF = 16'h0000;
	localparam int SSL_TOP_BIT = 15;
	localparam int SSL_SYNC_STAGES = 3;
	typedef enum logic [1:0] {
		SSL_ST_OFF = 2'b00,
		SSL_ST_PASS = 2'b01,
		SSL_ST_HOLD = 2'b10
	} ssl_mode_t;
endpackage : ssl_pkg

// >>> core/ssl_switch_control.sv
// Serial shift register, channel latch and force-off for a 16-channel switch
`timescale 1ns/1ps
module ssl_switch_control
	import ssl_pkg::*;
#(
	parameter int WIDTH = SSL_CHANNELS
)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic serial_clk_in,
	input wire logic serial_data_in,
	input wire logic latch_hold_n_in,
	input wire logic force_all_off_in,
	output logic chain_data_out,
	output logic [WIDTH-1:0] channel_state_out,
	output logic [1:0] mode_out
);

	// Shift chain lives on the serial clock; it has no reset pin of its own,
	// so it starts from a power-up value: all zero means every channel off
	logic [WIDTH-1:0] shift_r = '0;
	logic [WIDTH-1:0] shift_nxt;

	// Three-stage synchronisers for signals entering the core domain
	logic [SSL_SYNC_STAGES-1:0] hold_sync_r;
	logic [SSL_SYNC_STAGES-1:0] off_sync_r;
	logic hold_stable_r;
	logic off_stable_r;

	// Shift register word crosses by handshake: toggle per captured word
	// Power-up values keep the core from ever taking an unknown word
	logic [WIDTH-1:0] word_snap_r = '0;
	logic snap_tgl_r = 1'b0;
	logic [SSL_SYNC_STAGES-1:0] snap_sync_r;
	logic [WIDTH-1:0] word_core_r;

	ssl_mode_t mode_r;
	ssl_mode_t mode_nxt;
	logic [WIDTH-1:0] latch_r;
	logic [WIDTH-1:0] latch_nxt;

	// Next shift value: new bit enters stage 0, older bits move toward the top
	always_comb
	begin
		shift_nxt = {shift_r[WIDTH-2:0], serial_data_in};
	end

	// R2 rising edge sampling; R1 and R14 shifting never stops
	always_ff @(posedge serial_clk_in)
	begin
		shift_r <= shift_nxt;
	end

	// R6 chain from top stage; R19 channel 15 stage feeds it
	always_ff @(posedge serial_clk_in)
	begin
		chain_data_out <= shift_nxt[WIDTH-1];
	end

	// Snapshot of the shifted word with a toggle, so the core sees whole words only
	always_ff @(posedge serial_clk_in)
	begin
		word_snap_r <= shift_nxt;
		snap_tgl_r <= ~snap_tgl_r;
	end

	// Synchronise control pins; a change counts once stages two and three agree
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			hold_sync_r <= '0;
			off_sync_r <= '1;
			snap_sync_r <= '0;
			hold_stable_r <= 1'b0;
			off_stable_r <= 1'b1;
		end
		else
		begin
			hold_sync_r <= {hold_sync_r[SSL_SYNC_STAGES-2:0], latch_hold_n_in};
			off_sync_r <= {off_sync_r[SSL_SYNC_STAGES-2:0], force_all_off_in};
			snap_sync_r <= {snap_sync_r[SSL_SYNC_STAGES-2:0], snap_tgl_r};
			if (hold_sync_r[1] == hold_sync_r[2])
				hold_stable_r <= hold_sync_r[2];
			if (off_sync_r[1] == off_sync_r[2])
				off_stable_r <= off_sync_r[2];
		end
	end

	// Word capture: toggle seen stable means the snapshot has settled for a cycle
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			word_core_r <= SSL_SHIFT_RESET;
		else if (snap_sync_r[1] == snap_sync_r[2])
			word_core_r <= word_snap_r;
	end

	// Mode decode: force-off first, then hold, else pass through
	always_comb
	begin
		// R13 force-off wins
		if (off_stable_r)
			mode_nxt = SSL_ST_OFF;
		else if (hold_stable_r)
			mode_nxt = SSL_ST_HOLD;
		else
			mode_nxt = SSL_ST_PASS;
	end

	// Latch follows the word while transparent or forced off with hold low, otherwise keeps its value
	always_comb
	begin
		case (mode_nxt)
			// R4 transparent latch
			SSL_ST_PASS: latch_nxt = word_core_r;
			// R3 R5 freeze on hold
			SSL_ST_HOLD: latch_nxt = latch_r;
			SSL_ST_OFF: latch_nxt = hold_stable_r ? latch_r : word_core_r;
			default: latch_nxt = latch_r;
		endcase
	end

	// Latch register; reset state is all channels off
	always_ff @(posedge clk_in)
	begin
		// R16 off at power-up
		if (!rst_n_in)
		begin
			latch_r <= SSL_ALL_OFF;
			mode_r <= SSL_ST_OFF;
		end
		else
		begin
			latch_r <= latch_nxt;
			mode_r <= mode_nxt;
		end
	end

	// Channel outputs straight from flops; each bit drives only its own channel
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			channel_state_out <= SSL_ALL_OFF;
		// R11 R12 force-off gating
		else if (mode_nxt == SSL_ST_OFF)
			channel_state_out <= SSL_ALL_OFF;
		// R15 per-bit control
		else
			channel_state_out <= latch_nxt;
	end

	// Mode visible for status
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			mode_out <= SSL_ST_OFF;
		else
			mode_out <= mode_nxt;
	end

	// Checks on the core domain
	property p_off_forces_zero;
		@(posedge clk_in) disable iff (!rst_n_in)
		off_stable_r |=> (channel_state_out == SSL_ALL_OFF);
	endproperty
	a_off_forces_zero: assert property (p_off_forces_zero) // R11
		else $error("channels on during force-off");

	property p_off_priority;
		@(posedge clk_in) disable iff (!rst_n_in)
		(off_stable_r && !hold_stable_r) |=> (mode_out == SSL_ST_OFF);
	endproperty
	a_off_priority: assert property (p_off_priority) // R13
		else $error("force-off lost priority");

	property p_hold_freezes;
		@(posedge clk_in) disable iff (!rst_n_in)
		(hold_stable_r && !off_stable_r && $past(hold_stable_r) && !$past(off_stable_r))
			|=> $stable(channel_state_out);
	endproperty
	a_hold_freezes: assert property (p_hold_freezes) // R5
		else $error("channels changed while held");

	property p_hold_edge;
		@(posedge clk_in) disable iff (!rst_n_in)
		($rose(hold_stable_r) && !off_stable_r) |=> (latch_r == $past(latch_r));
	endproperty
	a_hold_edge: assert property (p_hold_edge) // R3
		else $error("latch moved at hold edge");

	property p_transparent;
		@(posedge clk_in) disable iff (!rst_n_in)
		(!hold_stable_r && !off_stable_r) |=> (channel_state_out == $past(word_core_r));
	endproperty
	a_transparent: assert property (p_transparent) // R4
		else $error("latch not transparent");

	property p_release;
		@(posedge clk_in) disable iff (!rst_n_in)
		($fell(off_stable_r) && !hold_stable_r) |=> (channel_state_out == $past(word_core_r));
	endproperty
	a_release: assert property (p_release) // R12
		else $error("channels did not resume after force-off");

	property p_per_bit;
		@(posedge clk_in) disable iff (!rst_n_in)
		(mode_out == SSL_ST_PASS) |-> (channel_state_out == latch_r);
	endproperty
	a_per_bit: assert property (p_per_bit) // R15
		else $error("channel differs from its bit");

	property p_reset_off;
		@(posedge clk_in)
		!rst_n_in |=> (channel_state_out == SSL_ALL_OFF && latch_r == SSL_ALL_OFF);
	endproperty
	a_reset_off: assert property (p_reset_off) // R16
		else $error("channels on after reset");

	property p_reset_mode;
		@(posedge clk_in)
		!rst_n_in |=> (mode_out == SSL_ST_OFF);
	endproperty
	a_reset_mode: assert property (p_reset_mode) // R16
		else $error("mode not off after reset");

	// Mode status must follow the synchronised pin levels one cycle later
	property p_hold_mode;
		@(posedge clk_in) disable iff (!rst_n_in)
		(hold_stable_r && !off_stable_r) |=> (mode_out == SSL_ST_HOLD);
	endproperty
	a_hold_mode: assert property (p_hold_mode) // R5
		else $error("mode not hold while held");

	property p_pass_mode;
		@(posedge clk_in) disable iff (!rst_n_in)
		(!hold_stable_r && !off_stable_r) |=> (mode_out == SSL_ST_PASS);
	endproperty
	a_pass_mode: assert property (p_pass_mode) // R4
		else $error("mode not pass while transparent");

	property p_off_mode;
		@(posedge clk_in) disable iff (!rst_n_in)
		off_stable_r |=> (mode_out == SSL_ST_OFF);
	endproperty
	a_off_mode: assert property (p_off_mode) // R13
		else $error("mode not off while forced");

	// A held latch must survive a force-off pulse untouched
	property p_off_hold_keep;
		@(posedge clk_in) disable iff (!rst_n_in)
		(off_stable_r && hold_stable_r) |=> (latch_r == $past(latch_r));
	endproperty
	a_off_hold_keep: assert property (p_off_hold_keep) // R13
		else $error("held latch moved during force-off");

	// Filtered pin levels only move once stages two and three agree
	property p_hold_src;
		@(posedge clk_in) disable iff (!rst_n_in)
		$changed(hold_stable_r) |->
			(hold_stable_r == $past(hold_sync_r[2]) && $past(hold_sync_r[1]) == $past(hold_sync_r[2]));
	endproperty
	a_hold_src: assert property (p_hold_src) // R3
		else $error("hold level taken before it settled");

	property p_off_src;
		@(posedge clk_in) disable iff (!rst_n_in)
		$changed(off_stable_r) |->
			(off_stable_r == $past(off_sync_r[2]) && $past(off_sync_r[1]) == $past(off_sync_r[2]));
	endproperty
	a_off_src: assert property (p_off_src) // R11
		else $error("force-off level taken before it settled");

	// A settled toggle means the word snapshot is taken on the next edge
	property p_word_capture;
		@(posedge clk_in) disable iff (!rst_n_in)
		(snap_sync_r[1] == snap_sync_r[2]) |=> (word_core_r == $past(word_snap_r));
	endproperty
	a_word_capture: assert property (p_word_capture) // R4
		else $error("settled word not captured");

	// Checks on the serial domain
	property p_chain_delay;
		@(posedge serial_clk_in)
		##16 (chain_data_out == $past(serial_data_in, 16));
	endproperty
	a_chain_delay: assert property (p_chain_delay) // R6
		else $error("chain output not delayed by sixteen");

	property p_shift_in;
		@(posedge serial_clk_in)
		##1 (shift_r[0] == $past(serial_data_in));
	endproperty
	a_shift_in: assert property (p_shift_in) // R2
		else $error("serial bit not captured");

	property p_shift_move;
		@(posedge serial_clk_in)
		##1 (shift_r[WIDTH-1:1] == $past(shift_r[WIDTH-2:0]));
	endproperty
	a_shift_move: assert property (p_shift_move) // R1
		else $error("shift register did not move");

	property p_top_is_chain;
		@(posedge serial_clk_in)
		##1 (chain_data_out == shift_r[SSL_TOP_BIT]);
	endproperty
	a_top_is_chain: assert property (p_top_is_chain) // R19
		else $error("chain output not from top stage");

	// Chain output is one serial edge behind the stage below the top
	property p_chain_follow;
		@(posedge serial_clk_in)
		##1 (chain_data_out == $past(shift_r[WIDTH-2]));
	endproperty
	a_chain_follow: assert property (p_chain_follow) // R6
		else $error("chain output skipped a stage");

	// Main mode transitions worth seeing at least once

	c_pass: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		mode_out == SSL_ST_PASS ##1 mode_out == SSL_ST_HOLD);
	c_off: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		mode_out == SSL_ST_HOLD ##1 mode_out == SSL_ST_OFF);
	c_release: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		mode_out == SSL_ST_OFF ##1 mode_out == SSL_ST_PASS);
	c_off_to_hold: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		mode_out == SSL_ST_OFF ##1 mode_out == SSL_ST_HOLD);
	c_hold_to_pass: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		mode_out == SSL_ST_HOLD ##1 mode_out == SSL_ST_PASS);

endmodule : ssl_switch_control

// >>> dv/ssl_ctrl_model.sv
// Controller model that shifts words into the switch chain
`timescale 1ns/1ps
module ssl_ctrl_model #(
	// power-up wait, shortened from 500 us
	parameter int WAKE_NS = 100
)
(
	output logic serial_clk_out,
	output logic serial_data_out
);
	logic ready_r = 1'b0;

	// Serial clock stands still low outside frames
	initial
	begin
		serial_clk_out = 1'b0;
		serial_data_out = 1'b0;
		#WAKE_NS ready_r = 1'b1;
	end

	// sixteen bits, channel 15 first, 6 ns period
	task automatic send_word(input logic [15:0] word);
		wait (ready_r);
		#1.3;
		for (int i = 15; i >= 0; i--)
		begin
			serial_data_out = word[i];
			#3 serial_clk_out = 1'b1;
			#3 serial_clk_out = 1'b0;
		end
		// Released line shows the inverse, so a stale bit cannot pass
		serial_data_out = ~word[0];
		// load ends well before latch-hold rises
		#25;
	endtask : send_word
endmodule : ssl_ctrl_model

// >>> dv/tb_top.sv
// Self-checking bench for the switch shift-and-latch block
`timescale 1ns/1ps
module tb_top;
	import ssl_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic latch_hold_n_in = 1'b1;
	logic force_all_off_in = 1'b0;
	logic serial_clk_in;
	logic serial_data_in;
	logic chain_data_out;
	logic [15:0] channel_state_out;
	logic [1:0] mode_out;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;

	ssl_switch_control u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.serial_clk_in(serial_clk_in), .serial_data_in(serial_data_in),
		.latch_hold_n_in(latch_hold_n_in), .force_all_off_in(force_all_off_in),
		.chain_data_out(chain_data_out), .channel_state_out(channel_state_out),
		.mode_out(mode_out));
	ssl_ctrl_model u_ctl (.serial_clk_out(serial_clk_in), .serial_data_out(serial_data_in));

	// Core clock, 200 MHz
	always #2.5 clk_in = ~clk_in;

	// Hang guard: far above the few hundred cycles the tests need
	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	// Pins cross through synchronisers, so allow settling before looking
	task automatic settle(input logic hold, input logic force_off);
		@(posedge clk_in);
		latch_hold_n_in <= hold;
		force_all_off_in <= force_off;
		repeat (12) @(posedge clk_in);
		#1;
	endtask : settle

	task automatic t_hold;
		settle(1'b1, 1'b0);
		u_ctl.send_word(16'hA5C3);
		settle(1'b1, 1'b0);
		chk(channel_state_out, SSL_ALL_OFF, "held");
		chk({14'h0, mode_out}, {14'h0, SSL_ST_HOLD}, "mode");
		settle(1'b0, 1'b0);
		chk(channel_state_out, 16'hA5C3, "pulse");
		settle(1'b1, 1'b0);
		u_ctl.send_word(16'h1234);
		settle(1'b1, 1'b0);
		chk(channel_state_out, 16'hA5C3, "frozen");
		chk({15'h0, chain_data_out}, 16'h0000, "chain");
		$display("test hold done");
	endtask : t_hold

	task automatic t_force;
		settle(1'b1, 1'b1);
		chk(channel_state_out, SSL_ALL_OFF, "forced");
		chk({14'h0, mode_out}, {14'h0, SSL_ST_OFF}, "mode");
		u_ctl.send_word(16'hFFFF);
		settle(1'b1, 1'b1);
		chk(channel_state_out, SSL_ALL_OFF, "data ignored");
		chk({15'h0, chain_data_out}, 16'h0001, "chain");
		settle(1'b1, 1'b0);
		chk(channel_state_out, 16'hA5C3, "released");
		$display("test force done");
	endtask : t_force

	task automatic t_pass;
		settle(1'b0, 1'b0);
		chk(channel_state_out, 16'hFFFF, "open");
		chk({14'h0, mode_out}, {14'h0, SSL_ST_PASS}, "mode");
		u_ctl.send_word(16'h8001);
		settle(1'b0, 1'b0);
		chk(channel_state_out, 16'h8001, "follow");
		settle(1'b0, 1'b1);
		chk(channel_state_out, SSL_ALL_OFF, "override");
		$display("test pass done");
	endtask : t_pass

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	// Reset loads constants into every synchroniser, so two cycles suffice
	initial
	begin
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_hold();
		t_force();
		t_pass();
		tally_and_finish();
	end
endmodule : tb_top
